/* File: vpwl_pkg.sv */
// Package for the VPW link control block: register map, fields, timing.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
package vpwl_pkg;
    // Register byte offsets
    localparam logic [7:0] VPWL_CTRL1_OFS  = 8'h00;
    localparam logic [7:0] VPWL_CTRL2_OFS  = 8'h04;
    localparam logic [7:0] VPWL_VECTOR_OFS = 8'h08;
    localparam logic [7:0] VPWL_EVENT_OFS  = 8'h0C;
    // Control one field positions
    localparam int VPWL_IGN_BIT  = 7;
    localparam int VPWL_SYMBOL_CLOCK_SELECT_BIT = 6;
    localparam int VPWL_RHI_BIT  = 5;
    localparam int VPWL_RLO_BIT  = 4;
    localparam int VPWL_IE_BIT   = 1;
    localparam int VPWL_WCM_BIT  = 0;
    // Control two field positions
    localparam int VPWL_TRANSCEIVER_LOOPBACK_BIT = 7;
    localparam int VPWL_INTERNAL_LOOPBACK_BIT = 6;
    localparam int VPWL_FAST_BIT  = 5;
    localparam int VPWL_NORM_BIT_FORMAT_BIT  = 4;
    // Event register bit positions (on a write only the clear bit acts: it resets the vector)
    localparam int VPWL_EV_SOF_BIT   = 0;
    localparam int VPWL_EV_BRK_BIT   = 1;
    localparam int VPWL_EV_EOF_BIT   = 2;
    localparam int VPWL_EV_CLR_BIT   = 3;
    // Reset values
    localparam logic [7:0] VPWL_CTRL1_RST = 8'h00;
    localparam logic [7:0] VPWL_CTRL2_RST = 8'h00;
    localparam logic [7:0] VPWL_VEC_RST   = 8'h00;
    // State vector codes
    localparam logic [7:0] VPWL_VEC_WAKE  = 8'h20;
    localparam logic [7:0] VPWL_VEC_BREAK = 8'h1C;
    // Idle times on the bus in microseconds
    localparam int VPWL_CLK_MHZ    = 10;
    localparam int VPWL_T_EOF_US   = 280;
    localparam int VPWL_T_IFS_US   = 300;
    localparam int VPWL_EOF_CYC    = VPWL_T_EOF_US * VPWL_CLK_MHZ;
    localparam int VPWL_IFS_CYC    = VPWL_T_IFS_US * VPWL_CLK_MHZ;
    // Protocol states
    typedef enum logic [1:0] {
        VPWL_IDLE  = 2'b00,
        VPWL_RECV  = 2'b01,
        VPWL_HUNT  = 2'b10,
        VPWL_QUIET = 2'b11
    } vpwl_state_t;
endpackage

/* File: vpwl_link_ctrl.sv */
// Control-bit logic of a VPW single-wire link controller with AXI4-Lite slave.
// Assumes bus symbol decoders outside report SOF, BREAK and EOF as pulses.
//
// Behaviour
// - Ignore flag keeps receiver off until SOF
// - SOF or BREAK clears ignore flag
// - Ignore masks irqs except 20h, status reset
// - Ignore set mid-frame drops rest of frame
// - Symbol clock select picks 1.048576/1 MHz timing
// - Rate code divides oscillator by 1,2,4,8
// - Rate bits writable once after reset
// - Irq gate enables processor interrupt requests
// - Irq held until sources cleared; reset vector 00
// - Irq gate change keeps pending vector
// - Wait-clock bit stops clocks in wait mode
// - Transceiver loopback resets machine, stops driving
// - After transceiver loopback wait EOF, idle times
// - Internal loopback ties tx to rx, no wake
// - After internal loopback require idle EOF/IFS times
// - Fast bit: receive-only 41.6K, else 10.4K
// - BREAK clears fast bit, vector 1Ch
// - Normalization bit format selects CRC/no-CRC values
// - Fast traffic ignored unless fast enabled
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module vpwl_link_ctrl import vpwl_pkg::*; #(
    parameter int EOF_CYC = VPWL_EOF_CYC,
    parameter int IFS_CYC = VPWL_IFS_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Bus side
    input  wire logic        bus_rx,
    input  wire logic        tx_data,
    input  wire logic        sof_seen,
    input  wire logic        break_seen,
    input  wire logic        eof_seen,
    input  wire logic        fast_activity,
    input  wire logic        wake_edge,
    input  wire logic        cpu_wait,
    // Outputs to the protocol engine and bus
    output logic             serial_tx_output,
    output logic             tx_drive_en,
    output logic             serial_rx_input,
    output logic             rx_enable,
    output logic             tx_allowed,
    output logic             iface_tick,
    output logic             symbol_clock_select,
    output logic             fast_receive_bit,
    output logic             normalization_bit_crc,
    output logic             normalization_bit_nocrc,
    output logic             engine_reset,
    output logic             irq
);
    // All state of the block
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  aw_addr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  ctrl1;
        logic [7:0]  ctrl2;
        logic        rate_locked;
        logic [2:0]  div_cnt;
        logic        tick;
        logic [7:0]  vector;
        vpwl_state_t state;
        logic [15:0] idle_cnt;
        logic        rx_ok;
        logic        tx_ok;
        logic        tx_out;
        logic        tx_en;
        logic        rx_in;
        logic        irq;
        logic        eng_rst;
    } vpwl_regs_t;

    vpwl_regs_t s_q;
    vpwl_regs_t s_d;

    logic        wr_fire;
    logic [7:0]  wr_ctrl;
    logic        ign;
    logic        transceiver_loopback;
    logic        internal_loopback;
    logic        fast;
    logic [2:0]  div_max;
    logic        clk_run;

    // Next-state logic
    always_comb begin
        s_d     = s_q;
        ign     = s_q.ctrl1[VPWL_IGN_BIT];
        transceiver_loopback   = s_q.ctrl2[VPWL_TRANSCEIVER_LOOPBACK_BIT];
        internal_loopback   = s_q.ctrl2[VPWL_INTERNAL_LOOPBACK_BIT];
        fast    = s_q.ctrl2[VPWL_FAST_BIT];
        wr_ctrl = 8'h00;
        clk_run = !(cpu_wait && s_q.ctrl1[VPWL_WCM_BIT]);
        // Divider length from rate code
        case ({s_q.ctrl1[VPWL_RHI_BIT], s_q.ctrl1[VPWL_RLO_BIT]})
            2'b00:   div_max = 3'h0;
            2'b01:   div_max = 3'h1;
            2'b10:   div_max = 3'h3;
            default: div_max = 3'h7;
        endcase
        // Write channel capture, either order
        s_d.awready = !s_q.aw_got && !s_q.bvalid;
        s_d.wready  = !s_q.w_got && !s_q.bvalid;
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
            s_d.awready = 1'b0;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
            s_d.wready = 1'b0;
        end
        wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
        if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = 2'b00;
            wr_ctrl    = s_q.wstrb[0] ? s_q.wdata[7:0] : 8'h00;
            case (s_q.aw_addr & 8'hFC)
                VPWL_CTRL1_OFS: begin
                    if (s_q.wstrb[0]) begin
                        s_d.ctrl1[VPWL_IGN_BIT]  = wr_ctrl[VPWL_IGN_BIT];
                        s_d.ctrl1[VPWL_SYMBOL_CLOCK_SELECT_BIT] = wr_ctrl[VPWL_SYMBOL_CLOCK_SELECT_BIT];
                        s_d.ctrl1[VPWL_IE_BIT]   = wr_ctrl[VPWL_IE_BIT];
                        s_d.ctrl1[VPWL_WCM_BIT]  = wr_ctrl[VPWL_WCM_BIT];
                        if (!s_q.rate_locked) begin
                            s_d.ctrl1[VPWL_RHI_BIT] = wr_ctrl[VPWL_RHI_BIT];
                            s_d.ctrl1[VPWL_RLO_BIT] = wr_ctrl[VPWL_RLO_BIT];
                            s_d.rate_locked = 1'b1;
                        end
                    end
                end
                VPWL_CTRL2_OFS: begin
                    if (s_q.wstrb[0]) begin
                        s_d.ctrl2 = wr_ctrl & 8'hF0;
                    end
                end
                VPWL_EVENT_OFS: begin
                    if (wr_ctrl[VPWL_EV_CLR_BIT]) begin
                        s_d.vector = VPWL_VEC_RST;
                    end
                end
                VPWL_VECTOR_OFS: ;
                default: s_d.bresp = 2'b10;
            endcase
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // Read channel
        s_d.arready = !s_q.rvalid && !s_q.arready;
        if (s_axi_arvalid && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rresp   = 2'b00;
            case (s_axi_araddr & 8'hFC)
                VPWL_CTRL1_OFS:  s_d.rdata = {24'h000000, s_q.ctrl1};
                VPWL_CTRL2_OFS:  s_d.rdata = {24'h000000, s_q.ctrl2};
                VPWL_VECTOR_OFS: s_d.rdata = {24'h000000, s_q.vector};
                VPWL_EVENT_OFS:  s_d.rdata = {29'h0, s_q.state, s_q.rx_ok};
                default: begin
                    s_d.rdata = 32'h00000000;
                    s_d.rresp = 2'b10;
                end
            endcase
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        // Interface clock enable from oscillator clock
        s_d.tick = 1'b0;
        if (clk_run) begin
            if (s_q.div_cnt >= div_max) begin
                s_d.div_cnt = 3'h0;
                s_d.tick    = 1'b1;
            end else begin
                s_d.div_cnt = s_q.div_cnt + 3'h1;
            end
        end
        // Protocol state: receive gate and idle qualification
        s_d.eng_rst = transceiver_loopback && !s_q.ctrl2[VPWL_TRANSCEIVER_LOOPBACK_BIT] ? 1'b0 : transceiver_loopback;
        if (transceiver_loopback) begin
            s_d.state    = VPWL_HUNT;
            s_d.idle_cnt = 16'h0000;
        end else if (!clk_run) begin
            s_d.state = s_q.state;
        end else begin
            case (s_q.state)
                VPWL_IDLE: begin
                    if (sof_seen && !ign && !(fast_activity && !fast)) begin
                        s_d.state = VPWL_RECV;
                    end
                end
                VPWL_RECV: begin
                    if (ign || break_seen) begin
                        s_d.state = VPWL_IDLE;
                    end else if (eof_seen) begin
                        s_d.state = VPWL_IDLE;
                    end
                end
                VPWL_HUNT: begin
                    if (eof_seen) begin
                        s_d.state    = VPWL_QUIET;
                        s_d.idle_cnt = 16'h0000;
                    end
                end
                VPWL_QUIET: begin
                    if (!bus_rx && !internal_loopback) begin
                        s_d.idle_cnt = 16'h0000;
                    end else if (s_q.idle_cnt != 16'hFFFF) begin
                        s_d.idle_cnt = s_q.idle_cnt + 16'h0001;
                    end
                    if (32'(s_q.idle_cnt) + 1 >= IFS_CYC) begin
                        s_d.state = VPWL_IDLE;
                    end
                end
                default: s_d.state = VPWL_IDLE;
            endcase
        end
        // Internal loopback release restarts idle qualification; transceiver loop wins
        if (internal_loopback && !s_d.ctrl2[VPWL_INTERNAL_LOOPBACK_BIT] && !transceiver_loopback) begin
            s_d.state    = VPWL_QUIET;
            s_d.idle_cnt = 16'h0000;
        end
        s_d.rx_ok = (s_d.state == VPWL_RECV || s_d.state == VPWL_IDLE ||
                     (s_d.state == VPWL_QUIET && 32'(s_d.idle_cnt) >= EOF_CYC))
                    && !s_d.ctrl1[VPWL_IGN_BIT];
        s_d.tx_ok = s_d.state == VPWL_IDLE && !s_d.ctrl2[VPWL_FAST_BIT];
        // Bus events: ignore flag, fast bit, state vector
        if (sof_seen || break_seen) begin
            s_d.ctrl1[VPWL_IGN_BIT] = 1'b0;
        end
        if (break_seen) begin
            s_d.ctrl2[VPWL_FAST_BIT] = 1'b0;
            s_d.vector = VPWL_VEC_BREAK;
        end else if (wake_edge && !internal_loopback) begin
            s_d.vector = VPWL_VEC_WAKE;
        end else if (ign && s_q.vector != VPWL_VEC_WAKE) begin
            s_d.vector = VPWL_VEC_RST;
        end
        // Loopback routing and bus drive
        s_d.tx_en  = !s_d.ctrl2[VPWL_TRANSCEIVER_LOOPBACK_BIT] && !s_d.ctrl2[VPWL_INTERNAL_LOOPBACK_BIT];
        s_d.tx_out = s_d.tx_en ? tx_data : 1'b1;
        s_d.rx_in  = s_d.ctrl2[VPWL_INTERNAL_LOOPBACK_BIT] ? tx_data : bus_rx;
        // Interrupt: held while vector nonzero, gated by enable and ignore except for the wake vector 20h
        s_d.irq = (s_d.vector != VPWL_VEC_RST) &&
                  (s_d.ctrl1[VPWL_IE_BIT] || s_d.vector == VPWL_VEC_WAKE) &&
                  (!s_d.ctrl1[VPWL_IGN_BIT] || s_d.vector == VPWL_VEC_WAKE);
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q        <= '0;
            s_q.ctrl1  <= VPWL_CTRL1_RST;
            s_q.ctrl2  <= VPWL_CTRL2_RST;
            s_q.vector <= VPWL_VEC_RST;
            s_q.state  <= VPWL_QUIET;
            s_q.tx_out <= 1'b1;
            s_q.rx_in  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign serial_tx_output = s_q.tx_out;
    assign tx_drive_en      = s_q.tx_en;
    assign serial_rx_input  = s_q.rx_in;
    assign rx_enable        = s_q.rx_ok;
    assign tx_allowed       = s_q.tx_ok;
    assign iface_tick       = s_q.tick;
    assign symbol_clock_select = s_q.ctrl1[VPWL_SYMBOL_CLOCK_SELECT_BIT];
    assign fast_receive_bit    = s_q.ctrl2[VPWL_FAST_BIT];
    assign normalization_bit_crc   = !s_q.ctrl2[VPWL_NORM_BIT_FORMAT_BIT];
    assign normalization_bit_nocrc = s_q.ctrl2[VPWL_NORM_BIT_FORMAT_BIT];
    assign engine_reset = s_q.eng_rst;
    assign irq          = s_q.irq;

    // Checks
    rate_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.rate_locked |=> $stable(s_q.ctrl1[VPWL_RHI_BIT:VPWL_RLO_BIT]))
        else $error("rate bits changed after lock");
    ign_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sof_seen || break_seen) |=> !s_q.ctrl1[VPWL_IGN_BIT])
        else $error("ignore flag not cleared");
    break_vec_a: assert property (@(posedge clk) disable iff (!rst_n)
        break_seen |=> (s_q.vector == VPWL_VEC_BREAK && !s_q.ctrl2[VPWL_FAST_BIT]))
        else $error("break handling wrong");
    ign_rx_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.ctrl1[VPWL_IGN_BIT] |-> !s_q.rx_ok)
        else $error("receiver on while ignoring");
    irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.irq && s_q.vector != VPWL_VEC_WAKE) |-> s_q.ctrl1[VPWL_IE_BIT])
        else $error("irq without enable");
    transceiver_loopback_drv_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.ctrl2[VPWL_TRANSCEIVER_LOOPBACK_BIT] |-> !s_q.tx_en ##1 s_q.state == VPWL_HUNT)
        else $error("bus driven in loopback");
    internal_loopback_rx_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.ctrl2[VPWL_INTERNAL_LOOPBACK_BIT] |-> s_q.rx_in == $past(tx_data))
        else $error("loopback route wrong");
    ign_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.state == VPWL_RECV && s_q.ctrl1[VPWL_IGN_BIT] && !cpu_wait)
        |=> s_q.state != VPWL_RECV)
        else $error("frame kept while ignoring");
    ign_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.irq && s_q.ctrl1[VPWL_IGN_BIT]) |-> s_q.vector == VPWL_VEC_WAKE)
        else $error("irq not masked while ignoring");
    fast_tx_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.ctrl2[VPWL_FAST_BIT] |-> !s_q.tx_ok)
        else $error("tx allowed in fast receive");
endmodule

/* File: vpwl_bus_node.sv */
// Far-side model: transceiver and other nodes as seen by the link control block.
// Assumes the bench calls symbol(); the bus has a pull-up, so it idles at 1.
`timescale 1ns/1ps
module vpwl_bus_node (
    // Clock
    input  wire logic clk,
    // Bus level and decoded symbols
    output logic      bus_rx,
    output logic      sof_seen,
    output logic      break_seen,
    output logic      eof_seen,
    output logic      fast_activity,
    output logic      wake_edge
);
    logic in_frame;
    initial begin
        {sof_seen, break_seen, eof_seen, fast_activity, wake_edge, in_frame} = '0;
        bus_rx = 1'b1;
    end
    // Random levels inside a frame, pull-up level outside
    always @(posedge clk) begin
        bus_rx <= in_frame ? 1'($urandom) : 1'b1;
    end
    // One-cycle pulse: 0 SOF, 1 BREAK, 2 EOF, 3 wake edge, 4 SOF at fast speed
    task automatic symbol(input int k);
        @(posedge clk);
        sof_seen      <= (k == 0) || (k == 4);
        break_seen    <= (k == 1);
        eof_seen      <= (k == 2);
        wake_edge     <= (k == 3);
        fast_activity <= (k == 4);
        in_frame      <= (k == 0) || (k == 4) || (k == 3 && in_frame);
        @(posedge clk);
        {sof_seen, break_seen, eof_seen, wake_edge, fast_activity} <= '0;
    endtask
endmodule

/* File: vpw_link_control_bits_bench.sv */
// Self-checking bench for the VPW link control block.
// Assumes vpwl_pkg and vpwl_bus_node; idle times shortened to 20/30 cycles.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module vpw_link_control_bits_bench import vpwl_pkg::*;;
    localparam int IFS_T = 30;
    logic        clk, rst_n, tx_data, cpu_wait, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        bus_rx, sof_seen, break_seen, eof_seen, fast_activity, wake_edge;
    logic        serial_tx_output, tx_drive_en, serial_rx_input, rx_enable, tx_allowed;
    logic        iface_tick, symbol_clock_select, fast_receive_bit, engine_reset;
    logic        normalization_bit_crc, normalization_bit_nocrc;
    logic [33:0] exp_q[$];
    logic [33:0] e_m;
    int          fail_count, n_tests, cnt;

    vpwl_link_ctrl #(.EOF_CYC(20), .IFS_CYC(IFS_T)) dut (
        .clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .bus_rx(bus_rx), .tx_data(tx_data), .sof_seen(sof_seen), .break_seen(break_seen),
        .eof_seen(eof_seen), .fast_activity(fast_activity), .wake_edge(wake_edge),
        .cpu_wait(cpu_wait), .serial_tx_output(serial_tx_output), .tx_drive_en(tx_drive_en),
        .serial_rx_input(serial_rx_input), .rx_enable(rx_enable), .tx_allowed(tx_allowed),
        .iface_tick(iface_tick), .symbol_clock_select(symbol_clock_select),
        .fast_receive_bit(fast_receive_bit), .normalization_bit_crc(normalization_bit_crc),
        .normalization_bit_nocrc(normalization_bit_nocrc), .engine_reset(engine_reset),
        .irq(irq));
    vpwl_bus_node node (
        .clk(clk), .bus_rx(bus_rx), .sof_seen(sof_seen), .break_seen(break_seen),
        .eof_seen(eof_seen), .fast_activity(fast_activity), .wake_edge(wake_edge));

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Bounded wait step; a run-out ends the test
    task automatic bound(inout int n);
        n++;
        if (n > 200) begin
            fail_count++;
            $display("unexpected wait length: expected %h, seen %h", 200, n);
            summarize();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        logic aw, w;
        n = 0;
        aw = 1;
        w = 1;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (aw || w) begin
            @(posedge clk);
            bound(n);
            if (aw && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw = 0;
            end
            if (w && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w = 0;
            end
        end
        while (s_axi_bvalid !== 1'b1) begin
            @(posedge clk);
            bound(n);
        end
        s_axi_bready <= 1'b0;
    endtask
    // Read; the expected word is noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = 2'b00);
        int n;
        n = 0;
        exp_q.push_back({r, 24'h000000, e});
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk);
            bound(n);
        end while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge clk);
            bound(n);
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask
    // Monitor: each read answer against the oldest note
    always @(posedge clk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            e_m = exp_q.size() > 0 ? exp_q.pop_front() : 34'h3FFFFFFFF;
            `CHK("read word", e_m, {s_axi_rresp, s_axi_rdata})
        end
    end
    task automatic tick_gap(output int g);
        int n;
        n = 0;
        g = 0;
        @(posedge clk);
        while (iface_tick !== 1'b1) begin
            @(posedge clk);
            bound(n);
        end
        do begin
            @(posedge clk);
            g++;
        end while (iface_tick !== 1'b1 && g < 20);
    endtask
    task automatic ticks(input int w, output int c);
        c = 0;
        repeat (w) begin
            @(posedge clk);
            c += (iface_tick === 1'b1);
        end
    endtask
    task automatic idle_wait(output int g);
        g = 0;
        while (tx_allowed !== 1'b1) begin
            @(posedge clk);
            bound(g);
        end
    endtask

    initial begin
        void'($urandom(90));
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, tx_data, cpu_wait, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        fail_count = 0;
        n_tests = 0;
        cyc(6);
        rst_n <= 1'b1;
        rd(VPWL_CTRL1_OFS, VPWL_CTRL1_RST);
        rd(VPWL_CTRL2_OFS, VPWL_CTRL2_RST);
        rd(VPWL_VECTOR_OFS, VPWL_VEC_RST);
        rd(8'h10, 8'h00, 2'b10);
        // Every rate code divides, then locks against a second write
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            rst_n <= 1'b0;
            cyc(6);
            rst_n <= 1'b1;
            wr(VPWL_CTRL1_OFS, 8'(c << 4));
            tick_gap(cnt);
            `CHK("tick period", 1 << c, cnt)
            wr(VPWL_CTRL1_OFS, 8'((3 - c) << 4));
            rd(VPWL_CTRL1_OFS, 8'(c << 4));
        end
        // Wait mode with and without clock stop, then symbol clock and bit format selects
        wr(VPWL_CTRL1_OFS, 8'h31);
        cpu_wait <= 1'b1;
        cyc(2);
        ticks(24, cnt);
        `CHK("ticks, clocks stopped", 0, cnt)
        wr(VPWL_CTRL1_OFS, 8'h30);
        cyc(2);
        ticks(24, cnt);
        `CHK("ticks, clocks running", 3, cnt)
        cpu_wait <= 1'b0;
        for (int f = 0; f < 2; f++) begin
            wr(VPWL_CTRL1_OFS, 8'h30 | 8'(f << 6));
            wr(VPWL_CTRL2_OFS, 8'(f << 4));
            cyc(2);
            `CHK("symbol clock", 1'(f), symbol_clock_select)
            `CHK("nb with crc", 1'(1 - f), normalization_bit_crc)
            `CHK("nb without crc", 1'(f), normalization_bit_nocrc)
        end
        // Ignore flag, wake vector, SOF release
        wr(VPWL_CTRL2_OFS, 8'h00);
        s_axi_wstrb <= 4'($urandom) & 4'hE;
        wr(VPWL_CTRL2_OFS, 8'h10);
        s_axi_wstrb <= 4'hF;
        rd(VPWL_CTRL2_OFS, 8'h00);
        wr(VPWL_CTRL1_OFS, 8'hB0);
        cyc(2);
        `CHK("receiver while ignoring", 1'b0, rx_enable)
        node.symbol(3);
        cyc(3);
        `CHK("wake irq while masked", 1'b1, irq)
        rd(VPWL_VECTOR_OFS, VPWL_VEC_WAKE);
        wr(VPWL_EVENT_OFS, 8'h08);
        cyc(2);
        `CHK("irq after clear", 1'b0, irq)
        node.symbol(0);
        cyc(2);
        rd(VPWL_CTRL1_OFS, 8'h30);
        node.symbol(2);
        // BREAK in fast mode with gate off, then gate on
        wr(VPWL_CTRL2_OFS, 8'h20);
        cyc(2);
        `CHK("fast receive", 1'b1, fast_receive_bit)
        wr(VPWL_CTRL1_OFS, 8'hB0);
        node.symbol(1);
        cyc(3);
        `CHK("irq gated off", 1'b0, irq)
        `CHK("fast cleared", 1'b0, fast_receive_bit)
        rd(VPWL_CTRL2_OFS, 8'h00);
        rd(VPWL_CTRL1_OFS, 8'h30);
        rd(VPWL_VECTOR_OFS, VPWL_VEC_BREAK);
        wr(VPWL_CTRL1_OFS, 8'h32);
        cyc(2);
        `CHK("pending irq kept", 1'b1, irq)
        wr(VPWL_EVENT_OFS, 8'h08);
        cyc(2);
        `CHK("irq after clear", 1'b0, irq)
        // Internal loopback; polarity is non-inverted, no byte loaded
        wr(VPWL_CTRL2_OFS, 8'h40);
        repeat (6) begin
            tx_data <= 1'($urandom);
            cyc(2);
            `CHK("looped rx", tx_data, serial_rx_input)
            `CHK("bus released", 1'b0, tx_drive_en)
        end
        node.symbol(3);
        cyc(3);
        rd(VPWL_VECTOR_OFS, 8'h00);
        wr(VPWL_CTRL2_OFS, 8'h00);
        idle_wait(cnt);
        `CHK("idle before transmit", 1'b1, cnt >= IFS_T - 2)
        // Transceiver loopback, then EOF and idle
        wr(VPWL_CTRL2_OFS, 8'h80);
        cyc(2);
        `CHK("engine held", 1'b1, engine_reset)
        `CHK("bus not driven", 1'b0, tx_drive_en)
        wr(VPWL_CTRL2_OFS, 8'h00);
        cyc(40);
        `CHK("transmit before eof", 1'b0, tx_allowed)
        node.symbol(2);
        idle_wait(cnt);
        `CHK("idle after eof", 1'b1, cnt >= IFS_T - 2)
        `CHK("reception after eof", 1'b1, rx_enable)
        // Fast SOF ignored, normal frame entered, then cut by the ignore flag
        node.symbol(4);
        cyc(2);
        rd(VPWL_EVENT_OFS, 8'h01);
        node.symbol(0);
        cyc(2);
        rd(VPWL_EVENT_OFS, 8'h03);
        wr(VPWL_CTRL1_OFS, 8'hB0);
        rd(VPWL_EVENT_OFS, 8'h00);
        cyc(2);
        summarize();
    end
endmodule
